// ==== design/gmrp_pkg.sv ====
`default_nettype none
package gmrp_pkg;

    // ------------------------------------------------------------
    // Port modes
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        GMRP_MODE_MII  = 2'b00,
        GMRP_MODE_GMII = 2'b01,
        GMRP_MODE_TBI  = 2'b10
    } gmrp_mode_t;

    // Management shifter states
    typedef enum logic [0:0]
    {
        GMRP_MG_IDLE  = 1'b0,
        GMRP_MG_SHIFT = 1'b1
    } gmrp_mg_state_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int MDC_MIN_PERIOD_NS = 400;
    // Half period rounds up so the full period never drops below the minimum
    localparam int MDC_HALF_CYC      = (MDC_MIN_PERIOD_NS + 2 * SYS_CLK_PERIOD_NS - 1)
                                       / (2 * SYS_CLK_PERIOD_NS);
    localparam logic [2:0] MDC_DIV_LAST   = 3'(MDC_HALF_CYC - 1);
    localparam logic [2:0] MDC_DIV_RESET  = 3'h0;
    localparam logic [6:0] ALIVE_TIMEOUT  = 7'h40;

    // ------------------------------------------------------------
    // Management frame layout (bit index in send order)
    // ------------------------------------------------------------
    localparam logic [5:0]  MG_LAST_BIT    = 6'h3F;
    localparam logic [5:0]  MG_TA_FIRST    = 6'h2E;
    localparam logic [5:0]  MG_DATA_FIRST  = 6'h30;
    localparam logic [31:0] MG_PREAMBLE    = 32'hFFFFFFFF;
    localparam logic [1:0]  MG_START       = 2'h1;
    localparam logic [1:0]  MG_OP_READ     = 2'h2;
    localparam logic [1:0]  MG_OP_WRITE    = 2'h1;
    localparam logic [1:0]  MG_TURNAROUND  = 2'h2;

    // ------------------------------------------------------------
    // Receive path values
    // ------------------------------------------------------------
    localparam logic [7:0] FALSE_CARRIER_CODE = 8'h0E;
    localparam logic [7:0] MII_NIBBLE_MASK    = 8'h0F;
    localparam logic [9:0] TBI_RESET          = 10'h000;

endpackage

`default_nettype wire

// ==== design/gmrp_rx_port.sv ====
// What this block does
// - Management clock period is at least 400 ns, never above 2.5 MHz.
// - Management clock comes from the system clock, shared by all ports.
// - Management data moves synchronously to the management clock, both directions.
// - Link-up lamp is low while linked, high otherwise.
// - Activity lamp is low during transmit or receive traffic, else high.
// - Gigabit lamp is low at gigabit rate, high otherwise.
// - In gigabit modes the reference clock may replace the recovered receive clock.
// - TBI data is captured on rising edges of both split clocks.
// - In MII mode only receive data bits 3..0 are used.
// - GMII and MII data is sampled on the receive clock rising edge.
// - Receive-error counts only while receive-valid is high.
// - Error with a carrier code and no valid marks a false carrier.
// - In TBI the valid and error pins are code bits 8 and 9.
// - Lamp, management clock and management data outputs are released to high impedance during reset.
`timescale 1ns/1ns
`default_nettype none

module gmrp_rx_port (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 rx_clock_in_i,
    input  wire logic                 split_rx_clock_a_i,
    input  wire logic                 split_rx_clock_b_i,
    input  wire logic                 rx_reference_clock_i,
    input  wire gmrp_pkg::gmrp_mode_t mode_i,
    input  wire logic                 link_up_i,
    input  wire logic                 tx_active_i,
    input  wire logic                 pcs_rx_active_i,
    input  wire logic                 half_duplex_i,
    input  wire logic                 use_ref_clock_i,
    input  wire logic                 collision_in_i,
    input  wire logic [7:0]           rx_data_in_i,
    input  wire logic                 rx_valid_in_i,
    input  wire logic                 rx_error_in_i,
    input  wire logic                 mgmt_start_i,
    input  wire logic                 mgmt_read_i,
    input  wire logic [4:0]           mgmt_phy_addr_i,
    input  wire logic [4:0]           mgmt_reg_addr_i,
    input  wire logic [15:0]          mgmt_wdata_i,
    output logic      [15:0]          mgmt_rdata_o,
    output logic                      mgmt_busy_o,
    output logic                      mgmt_done_o,
    output logic                      mdc_o,
    output logic                      mdc_oe_o,
    input  wire logic                 mdio_i,
    output logic                      mdio_o,
    output logic                      mdio_oe_o,
    output logic                      link_up_lamp_o,
    output logic                      activity_lamp_o,
    output logic                      gig_speed_lamp_o,
    output logic                      lamp_oe_o,
    output logic                      collision_o,
    output logic                      false_carrier_o,
    output logic                      rx_lock_to_ref_o,
    output logic                      rx_clock_alive_o,
    output logic                      ref_clock_alive_o,
    output logic      [7:0]           rx_data_o,
    output logic                      rx_valid_o,
    output logic                      rx_error_o,
    output logic                      rx_false_carrier_o,
    output logic      [9:0]           tbi_code_a_o,
    output logic      [9:0]           tbi_code_b_o
);

    // ------------------------------------------------------------
    // Crossings into the system and receive clock domains
    // ------------------------------------------------------------
    logic [1:0] beat_q;
    logic       fc_tgl_q;
    logic       col_s;
    logic       mdio_s;
    logic       dv_s;
    logic       fc_tgl_s;
    logic [1:0] beat_s;
    logic       mii_q;
    logic       mii_rx_s;

    gmrp_sync #(.W(6)) u_sync_sys (
        .clk_i   (sys_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({beat_q, fc_tgl_q, rx_valid_o, mdio_i, collision_in_i}),
        .q_o     ({beat_s, fc_tgl_s, dv_s, mdio_s, col_s})
    );

    // Mode is cut to one registered bit so no multi-bit word crosses
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            mii_q <= 1'b0;
        else
            mii_q <= (mode_i == gmrp_pkg::GMRP_MODE_MII);
    end

    gmrp_sync #(.W(1)) u_sync_rx (
        .clk_i   (rx_clock_in_i),
        .rst_n_i (rst_n_i),
        .d_i     (mii_q),
        .q_o     (mii_rx_s)
    );

    // ------------------------------------------------------------
    // Output enables and lamps
    // ------------------------------------------------------------
    logic oe_q;
    logic link_lamp_q;
    logic act_lamp_q;
    logic gig_lamp_q;
    logic gig_mode;

    assign gig_mode = (mode_i != gmrp_pkg::GMRP_MODE_MII);

    // Drivers stay released until reset is gone
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            oe_q <= 1'b0;
        else
            oe_q <= 1'b1;
    end

    // Lamps are active low: a low level lights the LED
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            link_lamp_q <= 1'b1;
            act_lamp_q  <= 1'b1;
            gig_lamp_q  <= 1'b1;
        end
        else
        begin
            link_lamp_q <= ~link_up_i;
            // TBI receive traffic is judged by the PCS, not by the valid pin
            act_lamp_q  <= ~(tx_active_i | ((mode_i == gmrp_pkg::GMRP_MODE_TBI)
                                            ? pcs_rx_active_i : dv_s));
            gig_lamp_q  <= ~gig_mode;
        end
    end

    assign link_up_lamp_o   = link_lamp_q;
    assign activity_lamp_o  = act_lamp_q;
    assign gig_speed_lamp_o = gig_lamp_q;
    assign lamp_oe_o        = oe_q;
    assign mdc_oe_o         = oe_q;

    // ------------------------------------------------------------
    // Collision and false carrier events
    // ------------------------------------------------------------
    logic col_q;
    logic fc_prev_q;
    logic fc_pulse_q;

    // In TBI the collision pin carries a split clock, so it is ignored
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            col_q      <= 1'b0;
            fc_prev_q  <= 1'b0;
            fc_pulse_q <= 1'b0;
        end
        else
        begin
            col_q      <= col_s & half_duplex_i
                          & (mode_i != gmrp_pkg::GMRP_MODE_TBI);
            fc_prev_q  <= fc_tgl_s;
            fc_pulse_q <= fc_tgl_s ^ fc_prev_q;
        end
    end

    assign collision_o     = col_q;
    assign false_carrier_o = fc_pulse_q;

    // ------------------------------------------------------------
    // Clock presence watch: receive clock (0), reference clock (1)
    // ------------------------------------------------------------
    logic [1:0] lclk;
    logic [1:0] beat_prev_q;
    logic [1:0] alive_q;
    logic [6:0] tmr_q [2];
    logic       lock_q;

    assign lclk = {rx_reference_clock_i, rx_clock_in_i};

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_watch
            logic [4:0] div_q;

            // Divide down so the system clock can follow the beat
            always_ff @(posedge lclk[i] or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    div_q <= 5'h00;
                else
                    div_q <= div_q + 5'h01;
            end

            assign beat_q[i] = div_q[4];

            // Timer restarts on every beat edge; expiry means the clock stopped
            always_ff @(posedge sys_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    beat_prev_q[i] <= 1'b0;
                    tmr_q[i]       <= 7'h00;
                    alive_q[i]     <= 1'b0;
                end
                else
                begin
                    beat_prev_q[i] <= beat_s[i];
                    if (beat_s[i] != beat_prev_q[i])
                        tmr_q[i] <= 7'h00;
                    else if (tmr_q[i] != gmrp_pkg::ALIVE_TIMEOUT)
                        tmr_q[i] <= tmr_q[i] + 7'h01;
                    alive_q[i] <= (tmr_q[i] != gmrp_pkg::ALIVE_TIMEOUT);
                end
            end
        end
    endgenerate

    // Fall back to the reference clock only when receive timing is missing
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            lock_q <= 1'b0;
        else
            lock_q <= use_ref_clock_i & gig_mode & alive_q[1] & ~alive_q[0];
    end

    assign rx_clock_alive_o  = alive_q[0];
    assign ref_clock_alive_o = alive_q[1];
    assign rx_lock_to_ref_o  = lock_q;

    // ------------------------------------------------------------
    // Management clock and frame shifter
    // ------------------------------------------------------------
    gmrp_pkg::gmrp_mg_state_t state_q;
    logic [2:0]  div_q;
    logic        mdc_q;
    logic        mdc_rise;
    logic        mdc_fall;
    logic        pend_q;
    logic        rd_q;
    logic [63:0] shift_q;
    logic [5:0]  idx_q;
    logic        mdio_oe_q;
    logic [15:0] rdata_q;
    logic        done_q;

    assign mdc_rise = (div_q == gmrp_pkg::MDC_DIV_LAST) & ~mdc_q;
    assign mdc_fall = (div_q == gmrp_pkg::MDC_DIV_LAST) & mdc_q;

    // Free-running divider off the system clock, not the data clocks
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_q <= gmrp_pkg::MDC_DIV_RESET;
            mdc_q <= 1'b0;
        end
        else if (div_q == gmrp_pkg::MDC_DIV_LAST)
        begin
            div_q <= gmrp_pkg::MDC_DIV_RESET;
            mdc_q <= ~mdc_q;
        end
        else
            div_q <= div_q + 3'h1;
    end

    // Frame loads on request; first bit goes out at the next falling edge
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q   <= gmrp_pkg::GMRP_MG_IDLE;
            pend_q    <= 1'b0;
            rd_q      <= 1'b0;
            shift_q   <= 64'h0000000000000000;
            idx_q     <= 6'h00;
            mdio_oe_q <= 1'b0;
            done_q    <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                gmrp_pkg::GMRP_MG_IDLE:
                begin
                    if (mgmt_start_i && !pend_q)
                    begin
                        pend_q  <= 1'b1;
                        rd_q    <= mgmt_read_i;
                        shift_q <= {gmrp_pkg::MG_PREAMBLE, gmrp_pkg::MG_START,
                                    mgmt_read_i ? gmrp_pkg::MG_OP_READ : gmrp_pkg::MG_OP_WRITE,
                                    mgmt_phy_addr_i, mgmt_reg_addr_i,
                                    gmrp_pkg::MG_TURNAROUND, mgmt_wdata_i};
                    end
                    else if (pend_q && mdc_fall)
                    begin
                        pend_q    <= 1'b0;
                        state_q   <= gmrp_pkg::GMRP_MG_SHIFT;
                        idx_q     <= 6'h00;
                        mdio_oe_q <= 1'b1;
                    end
                end
                gmrp_pkg::GMRP_MG_SHIFT:
                begin
                    // Data changes only on falling edges, PHY samples on rising
                    if (mdc_fall)
                    begin
                        shift_q <= {shift_q[62:0], 1'b0};
                        idx_q   <= idx_q + 6'h01;
                        if (rd_q && idx_q == gmrp_pkg::MG_TA_FIRST - 6'h01)
                            mdio_oe_q <= 1'b0;
                        if (idx_q == gmrp_pkg::MG_LAST_BIT)
                        begin
                            state_q   <= gmrp_pkg::GMRP_MG_IDLE;
                            mdio_oe_q <= 1'b0;
                            done_q    <= 1'b1;
                        end
                    end
                end
                default:
                    state_q <= gmrp_pkg::GMRP_MG_IDLE;
            endcase
        end
    end

    // Read data is taken on rising edges of the management clock
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_q <= 16'h0000;
        else if (state_q == gmrp_pkg::GMRP_MG_SHIFT && rd_q && mdc_rise
                 && idx_q >= gmrp_pkg::MG_DATA_FIRST)
            rdata_q <= {rdata_q[14:0], mdio_s};
    end

    assign mdc_o        = mdc_q;
    assign mdio_o       = shift_q[63];
    assign mdio_oe_o    = mdio_oe_q;
    assign mgmt_rdata_o = rdata_q;
    assign mgmt_done_o  = done_q;
    assign mgmt_busy_o  = pend_q | (state_q != gmrp_pkg::GMRP_MG_IDLE);

    // ------------------------------------------------------------
    // MII / GMII receive capture (receive clock domain)
    // ------------------------------------------------------------
    logic [7:0] rxd_masked;
    logic       fc_cond;
    logic [7:0] rxd_q;
    logic       dv_q;
    logic       er_q;
    logic       fc_q;

    // Upper nibble is don't-care on MII and must not leak through
    assign rxd_masked = mii_rx_s
                        ? (rx_data_in_i & gmrp_pkg::MII_NIBBLE_MASK) : rx_data_in_i;
    assign fc_cond    = ~rx_valid_in_i & rx_error_in_i
                        & (rxd_masked == gmrp_pkg::FALSE_CARRIER_CODE);

    always_ff @(posedge rx_clock_in_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rxd_q    <= 8'h00;
            dv_q     <= 1'b0;
            er_q     <= 1'b0;
            fc_q     <= 1'b0;
            fc_tgl_q <= 1'b0;
        end
        else
        begin
            rxd_q <= rxd_masked;
            dv_q  <= rx_valid_in_i;
            er_q  <= rx_error_in_i & rx_valid_in_i;
            fc_q  <= fc_cond;
            // One toggle per false carrier episode, not per cycle
            if (fc_cond && !fc_q)
                fc_tgl_q <= ~fc_tgl_q;
        end
    end

    assign rx_data_o          = rxd_q;
    assign rx_valid_o         = dv_q;
    assign rx_error_o         = er_q;
    assign rx_false_carrier_o = fc_q;

    // ------------------------------------------------------------
    // TBI code group capture on both split clocks
    // ------------------------------------------------------------
    logic [9:0] code_a_q;
    logic [9:0] code_b_q;

    always_ff @(posedge split_rx_clock_a_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            code_a_q <= gmrp_pkg::TBI_RESET;
        else
            code_a_q <= {rx_error_in_i, rx_valid_in_i, rx_data_in_i};
    end

    always_ff @(posedge split_rx_clock_b_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            code_b_q <= gmrp_pkg::TBI_RESET;
        else
            code_b_q <= {rx_error_in_i, rx_valid_in_i, rx_data_in_i};
    end

    assign tbi_code_a_o = code_a_q;
    assign tbi_code_b_o = code_b_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_MDC_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(mdc_q) |-> mdc_q [*4] ##1 !mdc_q) else $error("mdc high phase wrong");
    AST_MDC_LOW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(mdc_q) |-> !mdc_q [*4] ##1 mdc_q) else $error("mdc low phase wrong");
    AST_MDIO_SYNC: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_q == gmrp_pkg::GMRP_MG_SHIFT && $changed(shift_q[63])) |-> $fell(mdc_q))
        else $error("mdio changed away from mdc fall");
    AST_LINK_LAMP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(oe_q) |-> link_up_lamp_o == !$past(link_up_i)) else $error("link lamp wrong");
    AST_ACT_LAMP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tx_active_i |=> !activity_lamp_o) else $error("activity lamp not lit");
    AST_GIG_LAMP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(oe_q) |-> gig_speed_lamp_o == ($past(mode_i) == gmrp_pkg::GMRP_MODE_MII))
        else $error("gig lamp wrong");
    AST_RESET_HIZ: assert property (@(negedge sys_clk_i)
        !rst_n_i |-> !lamp_oe_o && !mdc_oe_o && !mdio_oe_o) else $error("output driven in reset");
    AST_COL_SYNC: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(collision_o) |-> $past(collision_in_i, 3)) else $error("collision not synced");
    AST_MII_NIBBLE: assert property (@(posedge rx_clock_in_i) disable iff (!rst_n_i)
        mii_rx_s |=> rx_data_o[7:4] == 4'h0)
        else $error("upper nibble leaked");
    AST_ERR_QUAL: assert property (@(posedge rx_clock_in_i) disable iff (!rst_n_i)
        rx_error_o |-> rx_valid_o && $past(rx_error_in_i)) else $error("error without valid");
    AST_FALSE_CARRIER: assert property (@(posedge rx_clock_in_i) disable iff (!rst_n_i)
        fc_cond |=> rx_false_carrier_o && !rx_valid_o) else $error("false carrier missed");
    AST_TBI_CAPTURE: assert property (@(posedge split_rx_clock_a_i) disable iff (!rst_n_i)
        1'b1 |=> tbi_code_a_o == $past({rx_error_in_i, rx_valid_in_i, rx_data_in_i}))
        else $error("tbi code group lost");

    COV_MG_READ: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_q && done_q);
    COV_FALSE_CARRIER: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        false_carrier_o);
    COV_COLLISION: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(collision_o));
    COV_REF_LOCK: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(rx_lock_to_ref_o));

endmodule

`default_nettype wire

// ==== design/gmrp_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Two-stage level synchroniser
// ------------------------------------------------------------
module gmrp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] hold_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            hold_q <= '0;
        end
        else
        begin
            meta_q <= d_i;
            hold_q <= meta_q;
        end
    end

    assign q_o = hold_q;

endmodule

`default_nettype wire

// ==== tb/gigabit_mii_receive_port_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module gigabit_mii_receive_port_bench;
    logic sys_clk_i = 0, rst_n_i = 0, link_up_i = 0, tx_active_i = 0, half_duplex_i = 0;
    logic collision_in_i = 0, mgmt_start_i = 0, mgmt_read_i = 0, phy_oe, phy_mdio, mdio_i;
    logic rx_clock_in_i, split_rx_clock_a_i, split_rx_clock_b_i, rx_reference_clock_i;
    logic rx_valid_in_i, rx_error_in_i, mdc_o, mdc_oe_o, mdio_o, mdio_oe_o, lamp_oe_o;
    logic mgmt_busy_o, mgmt_done_o, link_up_lamp_o, activity_lamp_o, gig_speed_lamp_o;
    logic collision_o, false_carrier_o, rx_lock_to_ref_o, rx_clock_alive_o;
    logic ref_clock_alive_o, rx_valid_o, rx_error_o, rx_false_carrier_o;
    logic [4:0] mgmt_phy_addr_i = 5'h11, mgmt_reg_addr_i = 5'h0A;
    logic [15:0] mgmt_wdata_i = 16'h5A3C, mgmt_rdata_o;
    logic [7:0] rx_data_in_i, rx_data_o;
    logic [9:0] pins, tbi_code_a_o, tbi_code_b_o;
    logic [63:0] frame;
    gmrp_pkg::gmrp_mode_t mode_i = gmrp_pkg::GMRP_MODE_MII;
    int bad_count = 0, checks_done = 0, nbits = 0, fc_seen = 0;
    time t_rise = 0, per = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    // Board feeds the reference from the receive clock
    assign rx_reference_clock_i = rx_clock_in_i;
    assign {rx_error_in_i, rx_valid_in_i, rx_data_in_i} = pins;
    // Pull-up wins when nobody drives the management line
    assign mdio_i = mdio_oe_o ? mdio_o : (phy_oe ? phy_mdio : 1'b1);
    gmrp_phy_model phy_u (.mdc_i(mdc_o), .mdio_oe_i(mdio_oe_o), .rx_clk_o(rx_clock_in_i),
        .split_a_o(split_rx_clock_a_i), .split_b_o(split_rx_clock_b_i), .pins_o(pins),
        .phy_oe_o(phy_oe), .phy_mdio_o(phy_mdio));
    gmrp_rx_port dut_u (.sys_clk_i, .rst_n_i, .rx_clock_in_i, .split_rx_clock_a_i,
        .split_rx_clock_b_i, .rx_reference_clock_i, .mode_i, .link_up_i, .tx_active_i,
        .pcs_rx_active_i(1'b0), .half_duplex_i, .use_ref_clock_i(1'b0), .collision_in_i,
        .rx_data_in_i, .rx_valid_in_i, .rx_error_in_i, .mgmt_start_i, .mgmt_read_i,
        .mgmt_phy_addr_i, .mgmt_reg_addr_i, .mgmt_wdata_i, .mgmt_rdata_o, .mgmt_busy_o,
        .mgmt_done_o, .mdc_o, .mdc_oe_o, .mdio_i, .mdio_o, .mdio_oe_o, .link_up_lamp_o,
        .activity_lamp_o, .gig_speed_lamp_o, .lamp_oe_o, .collision_o, .false_carrier_o,
        .rx_lock_to_ref_o, .rx_clock_alive_o, .ref_clock_alive_o, .rx_data_o, .rx_valid_o,
        .rx_error_o, .rx_false_carrier_o, .tbi_code_a_o, .tbi_code_b_o);
    // Bits the device drives, taken where the line is steady
    always @(posedge mdc_o)
    begin
        per = $time - t_rise;
        t_rise = $time;
        if (mdio_oe_o) begin frame = {frame[62:0], mdio_o}; nbits++; end
    end
    // Count false carrier pulses away from the launching edge
    always @(negedge sys_clk_i) if (false_carrier_o === 1'b1) fc_seen++;
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_lamps(input logic on);
        @(posedge sys_clk_i);
        link_up_i <= on; tx_active_i <= on;
        mode_i <= on ? gmrp_pkg::GMRP_MODE_GMII : gmrp_pkg::GMRP_MODE_MII;
        repeat (8) @(negedge sys_clk_i);
        `CHK(link_up_lamp_o, ~on)
        `CHK(activity_lamp_o, ~on)
        `CHK(gig_speed_lamp_o, ~on)
        `CHK({lamp_oe_o, mdc_oe_o, rx_clock_alive_o, ref_clock_alive_o, rx_lock_to_ref_o}, 5'h1E)
    endtask
    task automatic t_rx(input gmrp_pkg::gmrp_mode_t m, input logic [9:0] c,
                        input logic [10:0] exp);
        @(posedge sys_clk_i) mode_i <= m;
        repeat (4) @(posedge rx_clock_in_i);
        phy_u.put(c);
        repeat (2) @(posedge rx_clock_in_i);
        #5;
        if (m == gmrp_pkg::GMRP_MODE_TBI) `CHK({tbi_code_a_o, tbi_code_b_o}, {c, c})
        else `CHK({rx_false_carrier_o, rx_error_o, rx_valid_o, rx_data_o}, exp)
    endtask
    task automatic t_col(input logic h);
        @(posedge sys_clk_i) half_duplex_i <= h; collision_in_i <= 1'b1;
        mode_i <= gmrp_pkg::GMRP_MODE_MII;
        repeat (5) @(negedge sys_clk_i);
        `CHK(collision_o, h)
    endtask
    task automatic t_mgmt(input logic rd);
        int i;
        nbits = 0;
        @(posedge sys_clk_i) mgmt_start_i <= 1'b1; mgmt_read_i <= rd;
        @(posedge sys_clk_i) mgmt_start_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK(mgmt_busy_o, 1'b1)
        for (i = 0; i < 700 && mgmt_done_o !== 1'b1; i++) @(negedge sys_clk_i);
        `CHK({mgmt_done_o, mgmt_busy_o}, 2'b10)
        `CHK(per, 400)
        if (rd) `CHK(mgmt_rdata_o, 16'hC3A5)
        else `CHK({nbits, frame}, {32'd64, 36'hFFFFFFFF5, 5'h11, 5'h0A, 2'h2, 16'h5A3C})
    endtask
    initial
    begin
        phy_u.put(10'h000);
        @(negedge sys_clk_i);
        `CHK({lamp_oe_o, mdc_oe_o, mdio_oe_o}, 3'h0)
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_lamps(1'b1); t_lamps(1'b0);
        t_rx(gmrp_pkg::GMRP_MODE_MII, 10'h1A5, 11'h105);
        t_rx(gmrp_pkg::GMRP_MODE_GMII, 10'h3A5, 11'h3A5);
        t_rx(gmrp_pkg::GMRP_MODE_MII, 10'h2FE, 11'h40E);
        t_rx(gmrp_pkg::GMRP_MODE_TBI, 10'h2C7, 11'h000);
        t_col(1'b1); t_col(1'b0);
        t_mgmt(1'b0); t_mgmt(1'b1);
        `CHK(fc_seen, 1)
        close_out;
    end
    // Two frames of about 520 cycles each dominate the run
    initial
    begin
        #400000 bad_count++;
        close_out;
    end
endmodule
`default_nettype wire

// ==== tb/gmrp_phy_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// PHY and SerDes stand-in
// ------------------------------------------------------------
module gmrp_phy_model #(
    parameter logic [15:0] RD_WORD = 16'hC3A5
) (
    input  wire logic       mdc_i,
    input  wire logic       mdio_oe_i,
    output logic            rx_clk_o,
    output logic            split_a_o,
    output logic            split_b_o,
    output logic [9:0]      pins_o,
    output logic            phy_oe_o,
    output logic            phy_mdio_o
);
    int cnt = 0;
    // Receive clock 125 ns, split pair half a period apart
    initial rx_clk_o = 1'b0;
    always
    begin
        #62 rx_clk_o = 1'b1;
        #63 rx_clk_o = 1'b0;
    end
    assign split_a_o = rx_clk_o;
    assign split_b_o = ~rx_clk_o;
    initial pins_o = 10'h000;
    // Pins move well clear of every sampling edge
    task automatic put(input logic [9:0] c);
        @(posedge rx_clk_o);
        #30 pins_o = c;
    endtask
    // Count falls since the device let go; TA low, then data MSB first
    always @(negedge mdc_i)
    begin
        #1 cnt = mdio_oe_i ? 0 : cnt + 1;
    end
    assign phy_oe_o = cnt >= 2 && cnt <= 18;
    assign phy_mdio_o = (cnt >= 3 && cnt <= 18) ? RD_WORD[18 - cnt] : 1'b0;
endmodule
`default_nettype wire
